// ===== rtl/sws_pkg.sv
// Package: constants and carrier types for the supply watchdog supervisor
package sws_pkg;

  // Clock rate and derived cycle counts
  localparam int unsigned CORE_CLK_HZ = 40_000_000;
  localparam int unsigned RESET_TIMEOUT_MS = 200;
  localparam int unsigned WDOG_LONG_MS = 1600;
  localparam int unsigned WDOG_SHORT_MS = 100;
  localparam int unsigned CE_HOLD_US = 16;
  localparam int unsigned STROBE_MIN_NS = 100;
  localparam int unsigned RESET_TIMEOUT_CYC = RESET_TIMEOUT_MS * (CORE_CLK_HZ / 1000);
  localparam int unsigned WDOG_LONG_CYC = WDOG_LONG_MS * (CORE_CLK_HZ / 1000);
  localparam int unsigned WDOG_SHORT_CYC = WDOG_SHORT_MS * (CORE_CLK_HZ / 1000);
  localparam int unsigned CE_HOLD_CYC = CE_HOLD_US * (CORE_CLK_HZ / 1_000_000);
  // External clock mode counts, in timebase input edges
  localparam int unsigned EXT_WDOG_NORMAL_CLKS = 1024;
  localparam int unsigned EXT_WDOG_FIRST_CLKS = 4096;
  localparam int unsigned EXT_RESET_CLKS = 2048;

  localparam int unsigned CNT_W = 27;
  localparam int unsigned CE_CNT_W = 10;

  // Three-level strobe decode, from the analog front end
  typedef struct packed {
    logic high;
    logic mid;
  } sws_strobe_type;

  // Supply condition indications
  typedef struct packed {
    logic below_threshold;
    logic below_backup;
  } sws_supply_type;

  // Reset sequencer states
  typedef enum logic [1:0] {
    SWS_ST_HOLD = 2'b00,
    SWS_ST_TIMEOUT = 2'b01,
    SWS_ST_RUN = 2'b10
  } sws_state_type;

endpackage

// ===== rtl/sws_supervisor.sv
// Digital core of the supply watchdog supervisor
`timescale 1ns/100ps

// Notes on behaviour
// R1: Reset low while supply below threshold
// R2: High reset is open-drain inverse of low
// R3: Hold resets for timeout after supply recovers
// R4: Backup switchover never drives reset directly
// R5: Supply-low flag follows threshold, no delay
// R6: Backup indicator high while on battery
// R7: Static strobe past timeout faults and resets
// R8: Fault held until next strobe transition
// R9: Every strobe change restarts watchdog count
// R10: Floating strobe suspends the watchdog
// R11: Watchdog idle while supply low or floating
// R12: Static strobe repeats timeout then reset pulse
// R13: Select high uses internal timebase, else external
// R14: Internal periods 100ms/1.6s, reset 200ms
// R15: External counts 1024, 4096 and 2048 clocks
// R16: Chip-enable passes only with good supply
// R17: Enable kept at most 16us into reset
// R18: Gated enable driven high while blocked
// R19: Backup mode needs both supply conditions
// R20: Synchronise analog indications before use
// R21: First period after reset is the long one
module sws_supervisor
  import sws_pkg::*;
(
  // Clock and synchronous reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Asynchronous indications and pins
  input wire sws_supply_type supply_in,
  input wire sws_strobe_type watchdog_strobe_in,
  input wire logic timebase_select,
  input wire logic timebase_input,
  input wire logic chip_enable_in_n,
  // Outputs toward the processor and memory
  output logic reset_out_n,
  output logic reset_out_oe,
  output logic watchdog_fault_n,
  output logic supply_low_n,
  output logic on_backup_supply,
  output logic chip_enable_out_n,
  output logic chip_enable_out_oe
);

  // Two-stage synchronisers, one cell per asynchronous input
  logic below_thr;
  logic below_bat;
  logic strobe_high;
  logic strobe_mid;
  logic sel_level;
  logic tb_level;
  logic ce_in_n;
  // Select pin high picks the internal timebase
  wire logic ext_sel = ~sel_level; // [R13]

  // Supply below reset threshold
  sws_sync_cell #(
    .RESET_VALUE(1'b0)
  ) u_sync_below_thr (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_in(supply_in.below_threshold),
    .sync_q(below_thr)
  ); // [R20]

  // Supply below backup supply
  sws_sync_cell #(
    .RESET_VALUE(1'b0)
  ) u_sync_below_bat (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_in(supply_in.below_backup),
    .sync_q(below_bat)
  ); // [R20]

  // Strobe logic level
  sws_sync_cell #(
    .RESET_VALUE(1'b0)
  ) u_sync_strobe_high (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_in(watchdog_strobe_in.high),
    .sync_q(strobe_high)
  ); // [R20]

  // Strobe floating indication
  sws_sync_cell #(
    .RESET_VALUE(1'b0)
  ) u_sync_strobe_mid (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_in(watchdog_strobe_in.mid),
    .sync_q(strobe_mid)
  ); // [R20]

  // Timebase select pin
  sws_sync_cell #(
    .RESET_VALUE(1'b0)
  ) u_sync_sel (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_in(timebase_select),
    .sync_q(sel_level)
  );

  // Timebase input: external clock or period select
  sws_sync_cell #(
    .RESET_VALUE(1'b0)
  ) u_sync_tb (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_in(timebase_input),
    .sync_q(tb_level)
  );

  // Incoming chip-enable, idle high
  sws_sync_cell #(
    .RESET_VALUE(1'b1)
  ) u_sync_ce (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_in(chip_enable_in_n),
    .sync_q(ce_in_n)
  );

  // Previous strobe level; starts at the synchroniser's reset level
  logic strobe_prev_q;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      strobe_prev_q <= 1'b0;
    end else begin
      strobe_prev_q <= strobe_high;
    end
  end

  // Previous timebase level, for rising-edge counting
  logic tb_prev_q;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      tb_prev_q <= 1'b0;
    end else begin
      tb_prev_q <= tb_level;
    end
  end

  // A change seen while floating is not a strobe edge
  wire logic strobe_edge = (strobe_high != strobe_prev_q) & ~strobe_mid;
  wire logic tb_rise = tb_level & ~tb_prev_q;
  // External mode counts timebase edges; internal mode counts every core cycle
  wire logic tick = ext_sel ? tb_rise : 1'b1; // [R13]

  // Period selection: external edge counts or internal cycle counts
  logic first_period_q;
  logic [CNT_W-1:0] rst_limit;
  logic [CNT_W-1:0] wd_limit;
  logic [CNT_W-1:0] ext_wd_limit;
  logic [CNT_W-1:0] int_wd_limit;
  // First period after a reset timeout uses the long count
  assign ext_wd_limit = first_period_q ? CNT_W'(EXT_WDOG_FIRST_CLKS) : CNT_W'(EXT_WDOG_NORMAL_CLKS); // [R15]
  // Timebase input high selects the long period in internal mode
  assign int_wd_limit = (first_period_q || tb_level) ? CNT_W'(WDOG_LONG_CYC) : CNT_W'(WDOG_SHORT_CYC); // [R14]
  // Reset timeout is the same in both internal settings
  assign rst_limit = ext_sel ? CNT_W'(EXT_RESET_CLKS) : CNT_W'(RESET_TIMEOUT_CYC); // [R14] [R15]
  assign wd_limit = ext_sel ? ext_wd_limit : int_wd_limit; // [R13]

  // Reset sequencer and watchdog counter
  sws_state_type state_q;
  sws_state_type state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic fault_q;
  logic fault_d;
  logic first_d;
  wire logic wd_active = ~below_thr & ~strobe_mid; // [R10] [R11]

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    fault_d = fault_q;
    first_d = first_period_q;
    // Any strobe change or idle condition clears the fault
    if (strobe_edge || !wd_active) begin
      fault_d = 1'b0; // [R8] [R11]
    end
    case (state_q)
      // Supply low: counter parked at zero
      SWS_ST_HOLD: begin
        cnt_d = '0;
        if (!below_thr) begin
          state_d = SWS_ST_TIMEOUT; // [R3]
        end
      end
      // Reset timeout: count ticks, then release
      SWS_ST_TIMEOUT: begin
        if (tick) begin
          cnt_d = cnt_q + CNT_W'(1);
        end
        if (cnt_q >= rst_limit) begin
          state_d = SWS_ST_RUN; // [R3] [R12]
          cnt_d = '0;
          first_d = 1'b1; // [R21]
        end
      end
      // Watchdog running: restart on each strobe change
      SWS_ST_RUN: begin
        if (!wd_active || strobe_edge) begin
          cnt_d = '0; // [R9] [R10]
          if (strobe_edge) begin
            first_d = 1'b0; // [R21]
          end
        end else begin
          if (tick) begin
            cnt_d = cnt_q + CNT_W'(1);
          end
          if (cnt_q >= wd_limit) begin
            state_d = SWS_ST_TIMEOUT; // [R7] [R12]
            cnt_d = '0;
            fault_d = 1'b1; // [R7]
          end
        end
      end
      default: begin
        state_d = SWS_ST_HOLD;
        cnt_d = '0;
      end
    endcase
    // Supply low overrides every state
    if (below_thr) begin
      state_d = SWS_ST_HOLD; // [R1] [R4]
      cnt_d = '0;
      fault_d = 1'b0; // [R11]
    end
  end

  // Sequencer state and counter
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_q <= SWS_ST_HOLD;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // Fault flag and first-period flag; the first period after power-up is long
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      fault_q <= 1'b0;
      first_period_q <= 1'b1;
    end else begin
      fault_q <= fault_d;
      first_period_q <= first_d; // [R21]
    end
  end

  // Both reset outputs follow the sequencer
  wire logic reset_active = (state_q != SWS_ST_RUN);

  // Chip-enable gate: timer limits how long a held enable survives reset
  logic [CE_CNT_W-1:0] ce_cnt_q;
  logic ce_pass_q;
  wire logic ce_window = (ce_cnt_q < CE_CNT_W'(CE_HOLD_CYC)); // [R17]
  wire logic ce_keep = ce_pass_q & ~ce_in_n & ce_window; // [R17]
  // Once blocked the gate stays shut until reset ends; the timer saturates
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ce_cnt_q <= '0;
      ce_pass_q <= 1'b0;
    end else if (!reset_active) begin
      ce_cnt_q <= '0;
      ce_pass_q <= 1'b1;
    end else begin
      if (ce_window) begin
        ce_cnt_q <= ce_cnt_q + CE_CNT_W'(1);
      end
      ce_pass_q <= ce_keep; // [R17]
    end
  end

  // Next values of the outputs
  wire logic reset_out_n_d = ~reset_active; // [R1] [R3] [R7]
  wire logic supply_low_n_d = ~below_thr; // [R5]
  wire logic on_backup_supply_d = below_thr & below_bat; // [R6] [R19]
  // Gate passes the incoming enable only while running on a good supply
  wire logic gate_open = ~reset_active & ~below_thr; // [R16]
  wire logic chip_enable_out_n_d = gate_open ? ce_in_n : ~ce_keep; // [R17] [R18]

  // Reset outputs; the open-drain enable pulls the high reset low when idle
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      reset_out_n <= 1'b0;
      reset_out_oe <= 1'b0;
    end else begin
      reset_out_n <= reset_out_n_d;
      reset_out_oe <= reset_out_n_d; // [R2]
    end
  end

  // Status flags
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      watchdog_fault_n <= 1'b1;
      supply_low_n <= 1'b0;
      on_backup_supply <= 1'b0;
    end else begin
      watchdog_fault_n <= ~fault_d; // [R7] [R8]
      supply_low_n <= supply_low_n_d;
      on_backup_supply <= on_backup_supply_d;
    end
  end

  // Chip-enable output, always actively driven
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      chip_enable_out_n <= 1'b1;
      chip_enable_out_oe <= 1'b1;
    end else begin
      chip_enable_out_n <= chip_enable_out_n_d;
      chip_enable_out_oe <= 1'b1; // [R18]
    end
  end

endmodule

// Two flip-flop synchroniser for one asynchronous level
module sws_sync_cell #(
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic async_in,
  output logic sync_q
);

  // Only the second stage is read by the core logic
  // The first stage may go metastable and is never decoded
  logic stage1_q;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      stage1_q <= RESET_VALUE;
      sync_q <= RESET_VALUE;
    end else begin
      stage1_q <= async_in;
      sync_q <= stage1_q;
    end
  end

endmodule

// ===== tb/sws_host.sv
// Host model that toggles the watchdog strobe
`timescale 1ns/100ps
module sws_host
  import sws_pkg::*;
(
  input wire logic core_clk,
  input wire logic run,
  input wire logic flt,
  output sws_strobe_type strobe
);
  logic [3:0] cnt_q = 4'h0;
  logic hi_q = 1'b0;
  // Level held 16 cycles, well above the 4 cycle minimum
  always_ff @(posedge core_clk) begin
    cnt_q <= cnt_q + 4'h1;
    if (run && cnt_q == 4'hF) begin
      hi_q <= ~hi_q;
    end
  end
  assign strobe = '{high: hi_q, mid: flt};
endmodule

// ===== tb/sws_checker.sv
// Port checker for the supply watchdog supervisor
`timescale 1ns/100ps
module sws_checker
  import sws_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire sws_supply_type supply_in,
  input wire sws_strobe_type watchdog_strobe_in,
  input wire logic chip_enable_in_n,
  input wire logic reset_out_n,
  input wire logic reset_out_oe,
  input wire logic watchdog_fault_n,
  input wire logic supply_low_n,
  input wire logic on_backup_supply,
  input wire logic chip_enable_out_n,
  input wire logic chip_enable_out_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Five cycle windows cover the input paths: three cycles to the flags, four to the reset output
  a_reset_on_low: assert property (supply_in.below_threshold [*5] |-> !reset_out_n) else $error("rst");
  a_high_inverse: assert property (reset_out_oe == reset_out_n) else $error("inv");
  a_low_flag: assert property (supply_in.below_threshold [*5] |-> !supply_low_n) else $error("low");
  a_low_clear: assert property (!supply_in.below_threshold [*5] |-> supply_low_n) else $error("clr");
  a_backup_both: assert property ((!supply_in.below_backup || !supply_in.below_threshold) [*5]
    |-> !on_backup_supply) else $error("bat");
  a_fault_idle: assert property ((supply_in.below_threshold || watchdog_strobe_in.mid) [*5]
    |-> watchdog_fault_n) else $error("idle");
  a_fault_resets: assert property ($fell(watchdog_fault_n) |-> ##[0:1] !reset_out_n) else $error("wd");
  a_fault_sticky: assert property (($stable(watchdog_strobe_in) && !watchdog_strobe_in.mid
    && !supply_in.below_threshold) [*4] ##0 !watchdog_fault_n |=> !watchdog_fault_n) else $error("stk");
  a_ce_blocked: assert property (chip_enable_in_n [*5] |-> chip_enable_out_n) else $error("ce");
  a_ce_cutoff: assert property ($fell(reset_out_n) |-> ##[0:650] chip_enable_out_n) else $error("cut");
  a_ce_driven: assert property (chip_enable_out_oe) else $error("oe");
endmodule
bind sws_supervisor sws_checker u_sws_checker(.*);

// ===== tb/tb.sv
// Self-checking bench for the supply watchdog supervisor
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module tb;
  import sws_pkg::*;
  logic core_clk = 0, reset_n = 0, timebase_select = 0, timebase_input = 0, chip_enable_in_n = 0;
  logic run = 0, flt = 0;
  sws_supply_type supply_in = '0;
  sws_strobe_type watchdog_strobe_in;
  logic reset_out_n, reset_out_oe, watchdog_fault_n, supply_low_n, on_backup_supply;
  logic chip_enable_out_n, chip_enable_out_oe;
  int errors = 0, tests_run = 0;
  sws_supervisor u_sws_supervisor(.*);
  sws_host u_sws_host(.core_clk(core_clk), .run(run), .flt(flt), .strobe(watchdog_strobe_in));
  initial forever #12.5 core_clk = ~core_clk;
  // External timebase: one rising edge every two core cycles
  always @(posedge core_clk) timebase_input <= #1 ~timebase_input;
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic print_verdict;
    $display("tests %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic t_power_up;
    step(4000);
    `CHK(reset_out_n, 1'b0)
    `CHK(reset_out_oe, 1'b0)
    step(200);
    `CHK(reset_out_n, 1'b1)
    run = 1;
    $display("power_up done");
  endtask
  task automatic t_watchdog;
    step(10000);
    `CHK(watchdog_fault_n, 1'b1)
    run = 0;
    step(1900);
    `CHK(watchdog_fault_n, 1'b1)
    step(300);
    `CHK(watchdog_fault_n, 1'b0)
    `CHK(reset_out_n, 1'b0)
    step(3800);
    `CHK(reset_out_n, 1'b0)
    step(400);
    `CHK(reset_out_n, 1'b1)
    `CHK(watchdog_fault_n, 1'b0)
    step(4000);
    `CHK(reset_out_n, 1'b1)
    run = 1;
    step(100);
    `CHK(watchdog_fault_n, 1'b1)
    $display("watchdog done");
  endtask
  task automatic t_float;
    run = 0;
    flt = 1;
    step(3000);
    `CHK(watchdog_fault_n, 1'b1)
    `CHK(reset_out_n, 1'b1)
    flt = 0;
    run = 1;
    $display("float done");
  endtask
  task automatic t_brownout;
    chip_enable_in_n = 1;
    step(5);
    `CHK(chip_enable_out_n, 1'b1)
    `CHK(chip_enable_out_oe, 1'b1)
    chip_enable_in_n = 0;
    step(5);
    `CHK(chip_enable_out_n, 1'b0)
    supply_in.below_threshold = 1;
    step(5);
    `CHK(reset_out_n, 1'b0)
    `CHK(supply_low_n, 1'b0)
    `CHK(chip_enable_out_n, 1'b0)
    chip_enable_in_n = 1;
    step(5);
    `CHK(chip_enable_out_n, 1'b1)
    chip_enable_in_n = 0;
    step(5);
    `CHK(chip_enable_out_n, 1'b1)
    step(700);
    `CHK(chip_enable_out_n, 1'b1)
    `CHK(on_backup_supply, 1'b0)
    supply_in.below_backup = 1;
    step(5);
    `CHK(on_backup_supply, 1'b1)
    timebase_select = 1;
    supply_in = '0;
    step(5);
    `CHK(on_backup_supply, 1'b0)
    `CHK(supply_low_n, 1'b1)
    `CHK(reset_out_n, 1'b0)
    step(4400);
    `CHK(reset_out_n, 1'b0)
    $display("brownout done");
  endtask
  initial begin
    step(8);
    reset_n = 1;
    t_power_up;
    t_watchdog;
    t_float;
    t_brownout;
    print_verdict;
  end
  // Cut a hang short well after the expected run length
  initial begin
    #1500000;
    errors++;
    print_verdict;
  end
endmodule
